// ==== hw/orc_top.sv ====
// Over-range flags for channels A to C with clock-out mux on channel C
// Functional notes
// RULE1: Each channel's flag goes high whenever its sample magnitude exceeds the threshold.
// RULE2: A raised flag stays high for at least the programmed minimum pulse length.
// RULE3: The channel B flag is only active in four- and two-channel builds, else held low. The code enables it in any build of two or more channels.
// RULE4: The channel C flag exists only in the four-channel build.
// RULE5: The channel C pin carries a clock only when selected by pins or registers and PLL enable is high.
// RULE6: With selection zero or clock-out disabled by register, the channel C pin carries the C flag.
// RULE7: Selection 1 gives the reference clock, 2 gives it halved and 3 gives it quartered.
// RULE8: The channel C clock runs from reset on the pin selection alone, with PLL enabled and no power-down.
// RULE9: Power-down stops the reference clock output and the channel C clock.
// RULE10: In clock mode the C flag never reaches a pin and divided clocks stay in step with the reference.
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`include "orc_cfg.svh"

module orc_top
  import orc_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              SYS_RST,
  // Avalon-MM slave
  input  wire logic [3:0]        AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [31:0]       AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  // Interrupt
  output logic                   IRQ,
  // Converter samples, index 0 is channel A
  input  wire logic [2:0][11:0]  CHAN_SAMPLE,
  // Configuration pins, asynchronous
  input  wire logic [1:0]        CLOCK_OUT_SELECT_PINS,
  input  wire logic              PLL_ENABLE_PIN,
  input  wire logic              POWER_DOWN_PIN,
  // Flag and clock outputs
  output logic                   CHAN_A_OVERRANGE_OUT,
  output logic                   CHAN_B_OVERRANGE_OUT,
  output logic                   CHAN_C_OVERRANGE_OR_CLOCK_OUT,
  output logic                   PLL_REFERENCE_CLOCK_OUT
);

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  // Build variant: A always, B on two or more channels, C on four only
  localparam logic [2:0] CH_EN = {CHANNELS == 4, CHANNELS >= 2, 1'b1};
  localparam logic [3:0] REF_LAST = 4'(`ORC_REF_HALF_CYC - 1);

  // Pin synchronisers
  orc_pins_t pin_raw;
  orc_pins_t pin_meta_q;
  orc_pins_t pins_q;

  assign pin_raw = '{clk_sel: orc_clk_mode_t'(CLOCK_OUT_SELECT_PINS),
                     pll_en:  PLL_ENABLE_PIN,
                     pd:      POWER_DOWN_PIN};

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      pin_meta_q <= '{clk_sel: CM_FLAG, pll_en: 1'b0, pd: 1'b1};
      pins_q     <= '{clk_sel: CM_FLAG, pll_en: 1'b0, pd: 1'b1};
    end
    else
    begin
      pin_meta_q <= pin_raw;
      pins_q     <= pin_meta_q;
    end
  end

  // Register file and bus state
  logic [31:0] ctrl_d, ctrl_q;
  logic [2:0]  status_d, status_q;
  logic [2:0]  mask_d, mask_q;
  logic        ack_d, ack_q;
  logic [31:0] rdata_d, rdata_q;
  logic        irq_d, irq_q;
  logic        req;
  logic        accept;
  logic [31:0] bemask;
  logic [31:0] stat_word;

  logic [11:0] thr;
  logic [3:0]  minp_eff;
  logic [2:0]  flags;
  logic [2:0]  flags_d;
  logic [2:0]  evt;

  // Clock generation state
  logic [3:0]    div_d, div_q;
  logic [2:0]    ph_d, ph_q;
  logic          c_out_d, c_out_q;
  logic          run;
  logic          tick;
  logic          mode_on;
  logic          clk_v;
  orc_clk_mode_t sel_eff;

  assign thr      = ctrl_q[`ORC_CTRL_THR_MSB:`ORC_CTRL_THR_LSB];
  // Zero would mean no hold at all, so treat it as one sample
  assign minp_eff = (ctrl_q[`ORC_CTRL_MINP_MSB:`ORC_CTRL_MINP_LSB] == 4'h0) ? 4'h1 :
                    ctrl_q[`ORC_CTRL_MINP_MSB:`ORC_CTRL_MINP_LSB];

  // Per-channel detection with minimum pulse hold
  for (genvar gi = 0; gi < 3; gi++)
  begin : g_ch
    logic [11:0] mag;
    logic        over;
    logic [3:0]  hold_d, hold_q;
    logic        flag_d, flag_q;

    always_comb
    begin
      mag    = CHAN_SAMPLE[gi][11] ? 12'(~CHAN_SAMPLE[gi] + 12'h001) : CHAN_SAMPLE[gi];
      // RULE1: threshold compare
      // RULE3: B gated by variant
      // RULE4: C gated by variant
      over   = CH_EN[gi] && (mag > thr);
      hold_d = hold_q;
      // RULE2: minimum pulse hold
      if (over)
        hold_d = minp_eff;
      else if (hold_q != 4'h0)
        hold_d = hold_q - 4'h1;
      flag_d = (hold_d != 4'h0);
    end

    always_ff @(posedge CORE_CLK)
    begin
      if (SYS_RST)
      begin
        hold_q <= 4'h0;
        flag_q <= 1'b0;
      end
      else
      begin
        hold_q <= hold_d;
        flag_q <= flag_d;
      end
    end

    assign flags[gi]   = flag_q;
    assign flags_d[gi] = flag_d;
    assign evt[gi]     = flag_d & ~flag_q;
  end

  // Clock selection and division
  always_comb
  begin
    run   = pins_q.pll_en & ~pins_q.pd;
    tick  = (div_q == REF_LAST);
    div_d = 4'h0;
    ph_d  = 3'h0;
    // RULE9: power-down stops clocks
    if (run)
    begin
      div_d = tick ? 4'h0 : div_q + 4'h1;
      // RULE10: one counter keeps divided clocks in step
      ph_d  = tick ? ph_q + 3'h1 : ph_q;
    end
    // RULE6: register disable forces the flag
    if (ctrl_q[`ORC_CTRL_DIS_BIT])
      sel_eff = CM_FLAG;
    else if (ctrl_q[`ORC_CTRL_OVR_BIT])
      sel_eff = orc_clk_mode_t'(ctrl_q[`ORC_CTRL_SEL_MSB:`ORC_CTRL_SEL_LSB]);
    else
      sel_eff = pins_q.clk_sel;
    // RULE7: ratio by selection
    unique case (sel_eff)
      CM_FLAG: clk_v = 1'b0;
      CM_REF:  clk_v = ph_d[0];
      CM_DIV2: clk_v = ph_d[1];
      CM_DIV4: clk_v = ph_d[2];
    endcase
    // RULE5: clock only with PLL enabled
    mode_on = pins_q.pll_en && (sel_eff != CM_FLAG);
    // RULE10: flag hidden in clock mode
    c_out_d = mode_on ? clk_v : flags_d[2];
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      div_q   <= 4'h0;
      ph_q    <= 3'h0;
      c_out_q <= 1'b0;
    end
    else
    begin
      div_q   <= div_d;
      ph_q    <= ph_d;
      c_out_q <= c_out_d;
    end
  end

  assign CHAN_A_OVERRANGE_OUT          = flags[0];
  assign CHAN_B_OVERRANGE_OUT          = flags[1];
  assign CHAN_C_OVERRANGE_OR_CLOCK_OUT = c_out_q;
  assign PLL_REFERENCE_CLOCK_OUT       = ph_q[0];

  // Bus slave: one wait state on every access
  assign req             = AVS_READ | AVS_WRITE;
  assign accept          = req & ack_q;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign AVS_READDATA    = rdata_q;
  assign IRQ             = irq_q;
  assign bemask          = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                            {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[`ORC_STAT_EVT_LSB +: 3]  = status_q;
    stat_word[`ORC_STAT_LIVE_LSB +: 3] = flags;
    stat_word[`ORC_STAT_SEL_LSB +: 2]  = sel_eff;
    stat_word[`ORC_STAT_MODE_BIT]      = mode_on;
    stat_word[`ORC_STAT_RUN_BIT]       = run;

    ack_d   = req & ~ack_q;
    rdata_d = rdata_q;
    if (AVS_READ && !ack_q)
    begin
      unique case (AVS_ADDRESS)
        `ORC_ADDR_CTRL:   rdata_d = ctrl_q;
        `ORC_ADDR_STATUS: rdata_d = stat_word;
        `ORC_ADDR_MASK:   rdata_d = {29'h0, mask_q};
        default:          rdata_d = 32'h0000_0000;
      endcase
    end

    ctrl_d = ctrl_q;
    mask_d = mask_q;
    if (accept && AVS_WRITE && AVS_ADDRESS == `ORC_ADDR_CTRL)
      ctrl_d = ((ctrl_q & ~bemask) | (AVS_WRITEDATA & bemask)) & `ORC_CTRL_WMASK;
    if (accept && AVS_WRITE && AVS_ADDRESS == `ORC_ADDR_MASK && AVS_BYTEENABLE[0])
      mask_d = AVS_WRITEDATA[2:0];

    // Clear only what the reader saw; a new event wins over the clear
    status_d = status_q;
    if (accept && AVS_READ && AVS_ADDRESS == `ORC_ADDR_STATUS)
      status_d = status_q & ~rdata_q[`ORC_STAT_EVT_LSB +: 3];
    status_d = status_d | evt;
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_q   <= `ORC_CTRL_RST;
      status_q <= `ORC_STAT_RST;
      mask_q   <= `ORC_MASK_RST;
      ack_q    <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      irq_q    <= 1'b0;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      status_q <= status_d;
      mask_q   <= mask_d;
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
    end
  end

  // Helper: length of the latest channel A pulse
  logic [4:0] hi_cnt_q;

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      hi_cnt_q <= 5'h00;
    else if (!flags[0])
      hi_cnt_q <= 5'h00;
    else if (hi_cnt_q != 5'h1F)
      hi_cnt_q <= hi_cnt_q + 5'h01;
  end

  // RULE1: flag follows excess
  ovr_flag_a: assert property ((g_ch[0].over || g_ch[1].over) // RULE1
    |=> (flags[0] || !$past(g_ch[0].over)) && (flags[1] || !$past(g_ch[1].over)))
    else $error("flag missed an over-range sample");

  // RULE2: pulse not shorter than setting
  min_pulse_a: assert property ($fell(flags[0]) && $stable(minp_eff) |-> hi_cnt_q >= {1'b0, minp_eff}) // RULE2
    else $error("channel A pulse shorter than minimum");

  // RULE3: B silent in single build
  chan_b_off_a: assert property ((CHANNELS < 2) |-> !CHAN_B_OVERRANGE_OUT) // RULE3
    else $error("channel B flag active in single-channel build");

  // RULE4: C flag only on four channels
  chan_c_off_a: assert property ((CHANNELS != 4) && !mode_on |=> !CHAN_C_OVERRANGE_OR_CLOCK_OUT) // RULE4
    else $error("channel C flag active without four channels");

  // RULE5: PLL enable gates clock
  pll_gate_a: assert property (!pins_q.pll_en |=> CHAN_C_OVERRANGE_OR_CLOCK_OUT == flags[2]) // RULE5
    else $error("channel C not carrying flag with PLL disabled");

  // RULE6: zero selection shows flag
  flag_sel_a: assert property (sel_eff == CM_FLAG |=> CHAN_C_OVERRANGE_OR_CLOCK_OUT == flags[2]) // RULE6
    else $error("channel C not carrying flag with selection zero");

  // RULE7: undivided copy and halved clock
  ref_copy_a: assert property ((run && mode_on && sel_eff == CM_REF) [*2] // RULE7
    |-> CHAN_C_OVERRANGE_OR_CLOCK_OUT == PLL_REFERENCE_CLOCK_OUT)
    else $error("channel C not a copy of reference");
  div2_edge_a: assert property ($rose(CHAN_C_OVERRANGE_OR_CLOCK_OUT) && $past(mode_on && sel_eff == CM_DIV2) // RULE7
    && $past(mode_on && sel_eff == CM_DIV2, 2) |-> $fell(PLL_REFERENCE_CLOCK_OUT))
    else $error("halved clock out of step");

  // RULE8: clock runs from pin selection alone
  power_up_clk_a: assert property (run && mode_on && !ctrl_q[`ORC_CTRL_OVR_BIT] // RULE8
    |-> ##[1:20] ($changed(CHAN_C_OVERRANGE_OR_CLOCK_OUT) || !(run && mode_on)))
    else $error("channel C clock not running");

  // RULE9: power-down stops clocks
  pd_stop_a: assert property (pins_q.pd // RULE9
    |=> !PLL_REFERENCE_CLOCK_OUT && (!$past(mode_on) || !CHAN_C_OVERRANGE_OR_CLOCK_OUT))
    else $error("clock running during power-down");

  // RULE10: quartered clock in step
  div4_edge_a: assert property ($rose(CHAN_C_OVERRANGE_OR_CLOCK_OUT) && $past(mode_on && sel_eff == CM_DIV4) // RULE10
    && $past(mode_on && sel_eff == CM_DIV4, 2) |-> $fell(PLL_REFERENCE_CLOCK_OUT) && !ph_q[1])
    else $error("quartered clock out of step");

endmodule

// ==== include/orc_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the over-range block
`ifndef ORC_CFG_SVH
`define ORC_CFG_SVH

`define ORC_ADDR_CTRL      4'h0
`define ORC_ADDR_STATUS    4'h4
`define ORC_ADDR_MASK      4'h8

`define ORC_CTRL_THR_LSB   0
`define ORC_CTRL_THR_MSB   11
`define ORC_CTRL_MINP_LSB  16
`define ORC_CTRL_MINP_MSB  19
`define ORC_CTRL_OVR_BIT   24
`define ORC_CTRL_SEL_LSB   25
`define ORC_CTRL_SEL_MSB   26
`define ORC_CTRL_DIS_BIT   27
`define ORC_CTRL_WMASK     32'h0F0F_0FFF
`define ORC_CTRL_RST       32'h0004_0600

`define ORC_STAT_EVT_LSB   0
`define ORC_STAT_LIVE_LSB  4
`define ORC_STAT_SEL_LSB   8
`define ORC_STAT_MODE_BIT  10
`define ORC_STAT_RUN_BIT   11
`define ORC_STAT_RST       3'h0
`define ORC_MASK_RST       3'h0

`define ORC_CLK_MHZ        25
`define ORC_REF_HALF_NS    80
`define ORC_REF_HALF_CYC   ((`ORC_REF_HALF_NS * `ORC_CLK_MHZ + 999) / 1000)

`endif

// ==== include/orc_pkg.sv ====
// Types shared by the over-range and clock-out block
package orc_pkg;

  typedef enum logic [1:0]
  {
    CM_FLAG = 2'b00,
    CM_REF  = 2'b01,
    CM_DIV2 = 2'b10,
    CM_DIV4 = 2'b11
  } orc_clk_mode_t;

  typedef struct packed
  {
    orc_clk_mode_t clk_sel;
    logic          pll_en;
    logic          pd;
  } orc_pins_t;

endpackage

// ==== bench/orc_flag_monitor.sv ====
// Board-side logic that times the flag and clock pins of the block
module orc_flag_monitor
(
  // Clock
  input  wire logic clk,
  // Pins seen from the board
  input  wire logic a_pin,
  input  wire logic c_pin,
  input  wire logic r_pin,
  // Measurements in core cycles, plus rising-edge counts
  output int        a_len,
  output int        c_per,
  output int        r_per,
  output int        c_rise,
  output int        r_rise
);
  timeunit 1ns;
  timeprecision 1ps;
  int   a_cnt = 0;
  int   c_cnt = 0;
  int   r_cnt = 0;
  logic a_l   = 1'b0;
  logic c_l   = 1'b0;
  logic r_l   = 1'b0;

  initial
  begin
    {a_len, c_per, r_per, c_rise, r_rise} = '0;
  end

  // Samples like a synchronous receiver would, one look per edge
  always @(posedge clk)
  begin
    a_l <= a_pin;
    c_l <= c_pin;
    r_l <= r_pin;
    a_cnt <= a_pin ? a_cnt + 1 : 0;
    if (!a_pin && a_l)
      a_len <= a_cnt;
    c_cnt <= (c_pin && !c_l) ? 0 : c_cnt + 1;
    r_cnt <= (r_pin && !r_l) ? 0 : r_cnt + 1;
    if (c_pin && !c_l)
    begin
      c_per  <= c_cnt + 1;
      c_rise <= c_rise + 1;
    end
    if (r_pin && !r_l)
    begin
      r_per  <= r_cnt + 1;
      r_rise <= r_rise + 1;
    end
  end
endmodule

// ==== bench/orc_top_test.sv ====
// Self-checking bench for the over-range flags and clock-out mux
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end

module orc_top_test
  import orc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk   = 1'b0;
  logic             rst   = 1'b1;
  logic [3:0]       addr  = 4'h0;
  logic             rd    = 1'b0;
  logic             wr    = 1'b0;
  logic [31:0]      wdata = 32'h0000_0000;
  logic [2:0][11:0] smp   = '0;
  orc_pins_t        pins  = '{clk_sel: CM_REF, pll_en: 1'b1, pd: 1'b0};
  logic [31:0]      rdata;
  logic [31:0]      q;
  logic             wait_req, irq, fa, fb, fc, ref_clk, fa1, fb1, fc1;
  int               errors = 0;
  int               checked = 0;
  int               a_len, c_per, r_per, c_rise, r_rise, s1, s2;

  always #20 clk = ~clk;

  orc_top #(.CHANNELS(4)) DUT (.CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .IRQ(irq), .CHAN_SAMPLE(smp), .CLOCK_OUT_SELECT_PINS(pins.clk_sel),
    .PLL_ENABLE_PIN(pins.pll_en), .POWER_DOWN_PIN(pins.pd), .CHAN_A_OVERRANGE_OUT(fa),
    .CHAN_B_OVERRANGE_OUT(fb), .CHAN_C_OVERRANGE_OR_CLOCK_OUT(fc), .PLL_REFERENCE_CLOCK_OUT(ref_clk));
  // Single-channel build on the same stimulus, selection pins tied to flag mode
  orc_top #(.CHANNELS(1)) DUT_CH1 (.CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(),
    .AVS_WAITREQUEST(), .IRQ(), .CHAN_SAMPLE(smp), .CLOCK_OUT_SELECT_PINS(2'b00),
    .PLL_ENABLE_PIN(pins.pll_en), .POWER_DOWN_PIN(pins.pd), .CHAN_A_OVERRANGE_OUT(fa1),
    .CHAN_B_OVERRANGE_OUT(fb1), .CHAN_C_OVERRANGE_OR_CLOCK_OUT(fc1), .PLL_REFERENCE_CLOCK_OUT());
  orc_flag_monitor MON (.clk(clk), .a_pin(fa), .c_pin(fc), .r_pin(ref_clk), .a_len(a_len),
    .c_per(c_per), .r_per(r_per), .c_rise(c_rise), .r_rise(r_rise));

  task automatic end_sim();
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge; data taken at that same edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= d;
    do
    begin
      @(posedge clk);
    end
    while (wait_req !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic pulse(input logic [2:0] chs, input logic [11:0] v, input int len);
    @(posedge clk);
    for (int i = 0; i < 3; i++)
      if (chs[i])
        smp[i] <= v;
    repeat (len) @(posedge clk);
    smp <= '0;
    @(negedge clk);
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (40) @(posedge clk);
    `CHK("ref period", 4, r_per)
    `CHK("c period", 4, c_per)
    bus(0, 4'h0, 0, q);
    `CHK("ctrl reset", 32'h0004_0600, q)
    bus(0, 4'h8, 0, q);
    `CHK("mask reset", 3'h0, q[2:0])
    bus(0, 4'hC, 0, q);
    `CHK("unmapped", 32'h0000_0000, q)
    for (int m = 1; m < 4; m++)
    begin
      pins.clk_sel <= orc_clk_mode_t'(m);
      repeat (60) @(posedge clk);
      `CHK("c period", 4 << (m - 1), c_per)
    end
    bus(0, 4'h4, 0, q);
    `CHK("mode bit", 1'b1, q[10])
    // Power-down with an over-range on C: pin must stay quiet
    pins.pd <= 1'b1;
    repeat (8) @(posedge clk);
    s1 = c_rise;
    s2 = r_rise;
    pulse(3'b100, 12'h7FF, 20);
    `CHK("c hidden", 1'b0, fc)
    repeat (20) @(posedge clk);
    `CHK("c stopped", s1, c_rise)
    `CHK("ref stopped", s2, r_rise)
    pins.pd     <= 1'b0;
    pins.pll_en <= 1'b0;
    repeat (8) @(posedge clk);
    pulse(3'b100, 12'h7FF, 1);
    `CHK("c flag no pll", 1'b1, fc)
    @(posedge clk);
    pins.pll_en  <= 1'b1;
    pins.clk_sel <= CM_FLAG;
    repeat (8) @(posedge clk);
    bus(0, 4'h4, 0, q);
    pulse(3'b111, 12'h600, 1);
    repeat (4) @(posedge clk);
    bus(0, 4'h4, 0, q);
    `CHK("equal value", 3'h0, q[2:0])
    bus(1, 4'h8, 32'h0000_0001, q);
    pulse(3'b111, 12'h9FF, 1);
    `CHK("a flag", 1'b1, fa)
    `CHK("b flag", 1'b1, fb)
    `CHK("c flag", 1'b1, fc)
    `CHK("a flag 1ch", 1'b1, fa1)
    `CHK("b flag 1ch", 1'b0, fb1)
    `CHK("c flag 1ch", 1'b0, fc1)
    `CHK("irq set", 1'b1, irq)
    repeat (10) @(posedge clk);
    `CHK("pulse n4", 4, a_len)
    bus(0, 4'h4, 0, q);
    `CHK("events", 3'h7, q[2:0])
    repeat (2) @(posedge clk);
    `CHK("irq clear", 1'b0, irq)
    bus(0, 4'h4, 0, q);
    `CHK("events clear", 3'h0, q[2:0])
    bus(1, 4'h0, 32'h0007_0600, q);
    pulse(3'b001, 12'h601, 10);
    repeat (25) @(posedge clk);
    `CHK("pulse n7 held", 16, a_len)
    bus(1, 4'h0, 32'h0000_0600, q);
    pulse(3'b001, 12'h601, 1);
    repeat (5) @(posedge clk);
    `CHK("pulse n0", 1, a_len)
    // A events of the pulse-length tests would hold the line up
    bus(0, 4'h4, 0, q);
    `CHK("a event", 3'h1, q[2:0])
    pulse(3'b100, 12'h7FF, 1);
    `CHK("irq masked", 1'b0, irq)
    bus(0, 4'h4, 0, q);
    `CHK("c event", 3'h4, q[2:0])
    bus(1, 4'h0, 32'h0504_0600, q);
    repeat (60) @(posedge clk);
    `CHK("reg div2", 8, c_per)
    bus(0, 4'h0, 0, q);
    `CHK("ctrl back", 32'h0504_0600, q)
    bus(1, 4'h0, 32'h0D04_0600, q);
    repeat (4) @(posedge clk);
    pulse(3'b100, 12'h7FF, 1);
    `CHK("c flag dis", 1'b1, fc)
    end_sim();
  end
endmodule
